// file: hdl/bgd_line_if.sv
// Overview of operation
// - Logic one asserts the line, zero releases it.
// - Arbitration uses wired-OR drivers only.
// - Data and acknowledge may drive the released level.
// - Bits run at the slow or fast rate.
// - Gap timing uses the fixed arbitration clock.
// - Data XOR strobe edges capture receive data.
// - Idle means both receive lines unasserted.
// - Acknowledge gap after four idle arbitration clocks.
// - After acknowledge gap, drive at eight clocks.
// - Subaction gap after sixteen idle arbitration clocks.
// - After subaction gap, drive at twenty clocks.
// - Reset gap after twenty-eight idle arbitration clocks.
// - After reset gap, drive at thirty-two clocks.
// - Acknowledge gap precedes acknowledges and isochronous.
// - Subaction gap precedes asynchronous inside interval.
// - Reset gap precedes asynchronous at interval start.
// - Waiting node drives promptly once gap elapses.
// - Status bit zero flags arbitration reset gap.
// - Status bit one flags subaction gap.
`include "bgd_defs.svh"
`default_nettype none
module bgd_line_if (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                rx_data_line,
	input  wire logic                rx_strobe_line,
	input  wire logic                arb_mode,
	input  wire logic                xfer_mode,
	input  wire logic                fast_rate,
	input  wire logic                tx_req,
	input  wire bgd_pkg::bgd_gap_sel_t tx_gap_sel,
	input  wire logic                tx_valid,
	input  wire logic                tx_bit,
	input  wire logic                tx_last,
	output logic                     tx_ready,
	output logic                     tx_busy,
	output var bgd_pkg::bgd_line_t   tx_data_line,
	output var bgd_pkg::bgd_line_t   tx_strobe_line,
	output var bgd_pkg::bgd_status_t gap_status,
	output logic                     ack_gap,
	output logic                     rx_bit,
	output logic                     rx_bit_valid
);
	import bgd_pkg::*;

	// Idle count at which a transfer waiting for a gap may drive.
	function automatic logic [5:0] hold_of(input bgd_gap_sel_t sel);
		unique case (sel)
			GAP_ACK:       hold_of = `BGD_ACK_HOLD;
			GAP_SUB:       hold_of = `BGD_SUB_HOLD;
			GAP_ARB_RESET: hold_of = `BGD_ARB_HOLD;
			default:       hold_of = `BGD_ARB_HOLD;
		endcase
	endfunction

	// Two-stage synchronisers plus one history stage for edge finding.
	logic [2:0] rxd_q;          // Receive data pipe; bit 0 is first flop.
	logic [2:0] rxs_q;          // Receive strobe pipe.
	logic [2:0] rxd_d;
	logic [2:0] rxs_d;
	logic       rx_bit_q;       // Last captured NRZ bit.
	logic       rx_bit_d;
	logic       rx_valid_q;     // One-cycle pulse per captured bit.
	logic       rx_valid_d;
	logic       ds_edge;        // Recovered clock changed this cycle.
	logic       bus_idle;       // Both receive lines released.

	// The synchronised data and strobe are XORed; any change marks a bit.
	always_comb begin
		rxd_d      = {rxd_q[1:0], rx_data_line};
		rxs_d      = {rxs_q[1:0], rx_strobe_line};
		ds_edge    = (rxd_q[1] ^ rxs_q[1]) != (rxd_q[2] ^ rxs_q[2]);
		rx_bit_d   = ds_edge ? rxd_q[1] : rx_bit_q;
		rx_valid_d = ds_edge;
		bus_idle   = !rxd_q[1] && !rxs_q[1];
	end

	// Receive registers.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxd_q      <= 3'h0;
			rxs_q      <= 3'h0;
			rx_bit_q   <= 1'b0;
			rx_valid_q <= 1'b0;
		end else begin
			rxd_q      <= rxd_d;
			rxs_q      <= rxs_d;
			rx_bit_q   <= rx_bit_d;
			rx_valid_q <= rx_valid_d;
		end
	end

	// Arbitration clock made as a fractional tick of the system clock.
	// The tick has jitter of one system cycle but the right mean rate.
	logic [17:0] arb_acc_q;
	logic [17:0] arb_acc_d;
	logic        arb_tick;
	logic [5:0]  idle_q;        // Idle time in arbitration clocks.
	logic [5:0]  idle_d;
	logic        ack_q;         // Acknowledge gap seen.
	logic        sub_q;         // Subaction gap seen.
	logic        arst_q;        // Arbitration reset gap seen.
	logic        ack_d;
	logic        sub_d;
	logic        arst_d;

	// Gap counter: restarts on activity, counts ticks, stops at the top.
	always_comb begin
		arb_tick  = (arb_acc_q + `BGD_ARB_KHZ) >= `BGD_CLK_KHZ;
		arb_acc_d = arb_tick ? arb_acc_q + `BGD_ARB_KHZ - `BGD_CLK_KHZ
		                     : arb_acc_q + `BGD_ARB_KHZ;
		if (!bus_idle) begin
			idle_d = 6'h00;
		end else if (arb_tick && idle_q != `BGD_ARB_HOLD) begin
			idle_d = idle_q + 6'h01;
		end else begin
			idle_d = idle_q;
		end
		ack_d  = idle_q >= `BGD_ACK_DETECT;
		sub_d  = idle_q >= `BGD_SUB_DETECT;
		arst_d = idle_q >= `BGD_ARB_DETECT;
	end

	// Gap registers.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			arb_acc_q <= 18'h00000;
			idle_q    <= 6'h00;
			ack_q     <= 1'b0;
			sub_q     <= 1'b0;
			arst_q    <= 1'b0;
		end else begin
			arb_acc_q <= arb_acc_d;
			idle_q    <= idle_d;
			ack_q     <= ack_d;
			sub_q     <= sub_d;
			arst_q    <= arst_d;
		end
	end

	// Bit-rate tick for the transmitter, also fractional.
	// At the fast rate the tick fires on about four cycles in five; edges
	// then come at most once per system cycle, which is the best this clock can do.
	logic [17:0] tx_acc_q;
	logic [17:0] tx_acc_d;
	logic [17:0] tx_step;
	logic        tx_tick;
	bgd_state_t  st_q;
	bgd_state_t  st_d;
	logic        dval_q;        // Data line level being sent.
	logic        sval_q;        // Strobe line level being sent.
	logic        dval_d;
	logic        sval_d;
	bgd_line_t   dout_q;
	bgd_line_t   sout_q;
	bgd_line_t   dout_d;
	bgd_line_t   sout_d;
	logic        active;
	logic        totem;

	// Transmit sequencer, data-strobe encoder and driver mode.
	always_comb begin
		tx_step  = fast_rate ? `BGD_FAST_KBPS : `BGD_SLOW_KBPS;
		tx_tick  = (tx_acc_q + tx_step) >= `BGD_CLK_KHZ;
		tx_acc_d = tx_tick ? tx_acc_q + tx_step - `BGD_CLK_KHZ
		                   : tx_acc_q + tx_step;
		st_d     = st_q;
		dval_d   = dval_q;
		sval_d   = sval_q;
		tx_ready = 1'b0;
		unique case (st_q)
			ST_IDLE: begin
				// A request always waits for its gap first.
				if (tx_req) begin
					st_d = ST_WAIT_GAP;
				end
			end
			ST_WAIT_GAP: begin
				// Drive on the first cycle the hold-off is met.
				if (!tx_req) begin
					st_d = ST_IDLE;
				end else if (idle_q >= hold_of(tx_gap_sel)) begin
					st_d = ST_SEND;
				end
			end
			ST_SEND: begin
				// One bit per tick; an underrun repeats no edge.
				tx_ready = tx_tick;
				if (tx_tick && tx_valid) begin
					dval_d = tx_bit;
					sval_d = (tx_bit == dval_q) ? !sval_q : sval_q;
					if (tx_last) begin
						st_d = ST_DRAIN;
					end
				end
			end
			ST_DRAIN: begin
				// Hold the final bit for a full cell, then release.
				if (tx_tick) begin
					st_d   = ST_IDLE;
					dval_d = 1'b0;
					sval_d = 1'b0;
				end
			end
		endcase
		active   = (st_d == ST_SEND) || (st_d == ST_DRAIN);
		totem    = active && xfer_mode && !arb_mode;
		// Asserted level always sinks; released only driven in totem mode.
		dout_d.o  = active && dval_d;
		dout_d.oe = (active && dval_d) || totem;
		sout_d.o  = active && sval_d;
		sout_d.oe = (active && sval_d) || totem;
	end

	// Transmit registers.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_acc_q <= 18'h00000;
			st_q     <= ST_IDLE;
			dval_q   <= 1'b0;
			sval_q   <= 1'b0;
			dout_q   <= '0;
			sout_q   <= '0;
		end else begin
			tx_acc_q <= tx_acc_d;
			st_q     <= st_d;
			dval_q   <= dval_d;
			sval_q   <= sval_d;
			dout_q   <= dout_d;
			sout_q   <= sout_d;
		end
	end

	// Outputs, all from flip-flops except the ready handshake.
	always_comb begin
		tx_data_line               = dout_q;
		tx_strobe_line             = sout_q;
		gap_status                 = '0;
		gap_status.arb_reset_gap   = arst_q;
		gap_status.sub_gap         = sub_q;
		ack_gap                    = ack_q;
		tx_busy                    = st_q != ST_IDLE;
		rx_bit                     = rx_bit_q;
		rx_bit_valid               = rx_valid_q;
	end

	// Checks on the behaviour above.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence busy_s;
		!bus_idle;
	endsequence
	sequence start_s;
		st_q == ST_WAIT_GAP ##1 st_q == ST_SEND;
	endsequence

	idle_restart_a: assert property (busy_s |=> idle_q == 6'h00)
		else $error("idle count not cleared by activity");
	idle_ceiling_a: assert property (idle_q <= `BGD_ARB_HOLD)
		else $error("idle count past ceiling");
	ack_gap_a: assert property (ack_gap == ($past(idle_q) >= 6'd4))
		else $error("ack gap flag wrong");
	sub_gap_a: assert property (gap_status[1] ==
		($past(idle_q) >= 6'd16))
		else $error("subaction gap flag wrong");
	arst_gap_a: assert property (gap_status[0] ==
		($past(idle_q) >= 6'd28))
		else $error("reset gap flag wrong");
	hold_off_a: assert property (start_s |->
		$past(idle_q) >= hold_of($past(tx_gap_sel)))
		else $error("bus driven before hold-off");
	prompt_drive_a: assert property ((st_q == ST_WAIT_GAP && tx_req &&
		idle_q >= hold_of(tx_gap_sel)) |=> st_q == ST_SEND)
		else $error("drive not started promptly");
	wired_or_a: assert property (arb_mode |=>
		!(tx_data_line.oe && !tx_data_line.o) &&
		!(tx_strobe_line.oe && !tx_strobe_line.o))
		else $error("released level driven while arbitrating");
	rx_capture_a: assert property (ds_edge |=>
		rx_bit_valid && rx_bit == $past(rxd_q[1]))
		else $error("receive bit not captured on edge");
	ds_encode_a: assert property ((tx_ready && tx_valid) |=>
		tx_data_line.o == $past(tx_bit) &&
		tx_data_line.oe == ($past(tx_bit) || $past(totem)))
		else $error("data line level wrong");
endmodule
`default_nettype wire

// file: hdl/bgd_defs.svh
`ifndef BGD_DEFS_SVH
`define BGD_DEFS_SVH
// System clock and arbitration clock rates, in kHz.
`define BGD_CLK_KHZ    18'd125000
`define BGD_ARB_KHZ    18'd49152
// Serial bit rates, in kbit/s.
`define BGD_SLOW_KBPS  18'd49152
`define BGD_FAST_KBPS  18'd98304
// Gap thresholds, in arbitration clock periods.
`define BGD_ACK_DETECT 6'd4
`define BGD_ACK_HOLD   6'd8
`define BGD_SUB_DETECT 6'd16
`define BGD_SUB_HOLD   6'd20
`define BGD_ARB_DETECT 6'd28
`define BGD_ARB_HOLD   6'd32
// Status transfer bit positions.
`define BGD_STAT_ARB_BIT 0
`define BGD_STAT_SUB_BIT 1
`endif

// file: hdl/bgd_pkg.sv
`default_nettype none
package bgd_pkg;
	// One open-collector or totem-pole driver: level and enable.
	typedef struct packed {
		logic o;
		logic oe;
	} bgd_line_t;
	// Low nibble of the status transfer; bit 0 is the reset gap.
	typedef struct packed {
		logic [1:0] spare;
		logic       sub_gap;
		logic       arb_reset_gap;
	} bgd_status_t;
	// Which gap a pending transfer waits for.
	typedef enum logic [1:0] {
		GAP_ACK,
		GAP_SUB,
		GAP_ARB_RESET
	} bgd_gap_sel_t;
	// Transmit sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_GAP,
		ST_SEND,
		ST_DRAIN
	} bgd_state_t;
endpackage
`default_nettype wire

// file: sim/bgd_bus_model.sv
`default_nettype none
// Far side of the backplane: other nodes and the termination.
module bgd_bus_model (
	input  wire bgd_pkg::bgd_line_t tx_data_line,
	input  wire bgd_pkg::bgd_line_t tx_strobe_line,
	output logic                    rx_data_line,
	output logic                    rx_strobe_line
);
	timeunit 1ns;
	timeprecision 1ps;
	import bgd_pkg::*;
	logic drv_d = 1'b0; // A far node asserts data.
	logic drv_s = 1'b0; // A far node asserts strobe.
	// Wired-OR: any asserting driver wins, else termination pulls low.
	assign rx_data_line   = drv_d | (tx_data_line.o & tx_data_line.oe);
	assign rx_strobe_line = drv_s | (tx_strobe_line.o & tx_strobe_line.oe);
	// Sends bits data-strobe coded, one edge each half link period.
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			if (b[i] == drv_d)
				drv_s = ~drv_s;
			drv_d = b[i];
			#80;
		end
		// Lines are released together, so the bus goes idle at once.
		drv_d = 1'b0;
		drv_s = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: sim/bgd_line_if_test.sv
`include "bgd_defs.svh"
`default_nettype none
module bgd_line_if_test;
	timeunit 1ns;
	timeprecision 1ps;
	import bgd_pkg::*;
	logic         clk, resetn, arb_mode, xfer_mode, fast_rate;
	logic         tx_req, tx_valid, tx_bit, tx_last;
	bgd_gap_sel_t tx_gap_sel;
	logic         rx_data_line, rx_strobe_line, tx_ready, tx_busy;
	logic         ack_gap, rx_bit, rx_bit_valid;
	bgd_line_t    tx_data_line, tx_strobe_line;
	bgd_status_t  gap_status;
	int           fail_count = 0;
	int           checked = 0;
	logic         q_rx[$]; // Bits sent by the far side, not yet seen.
	int           hold[3] = '{`BGD_ACK_HOLD, `BGD_SUB_HOLD, `BGD_ARB_HOLD};
	bgd_line_if bgd_line_if_i (.clk, .resetn, .rx_data_line,
		.rx_strobe_line, .arb_mode, .xfer_mode, .fast_rate, .tx_req,
		.tx_gap_sel, .tx_valid, .tx_bit, .tx_last, .tx_ready, .tx_busy,
		.tx_data_line, .tx_strobe_line, .gap_status, .ack_gap, .rx_bit,
		.rx_bit_valid);
	bgd_bus_model bus (.tx_data_line, .tx_strobe_line, .rx_data_line,
		.rx_strobe_line);
	// The clock runs at 125 MHz.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("Error at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask
	// Clock cycles for n arbitration ticks plus synchroniser and flag.
	function automatic int exp_cyc(input int n);
		return n * `BGD_CLK_KHZ / `BGD_ARB_KHZ + 3;
	endfunction
	task automatic complete_run();
		$display("Checked %0d, failed %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Captured bits are matched in order; stray edges at release are
	// ignored because the queue is empty then.
	always @(negedge clk) begin
		if (rx_bit_valid === 1'b1 && q_rx.size() > 0)
			chk_bit(rx_bit, q_rx.pop_front());
	end
	// The whole run is under a thousand cycles; this cuts a hang short.
	initial begin
		#100000;
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run();
	end
	initial begin
		logic [7:0] b;
		logic       pb, ps;
		int         n, ta, ts, tot;
		{arb_mode, xfer_mode, fast_rate, tx_req} = '0;
		{tx_valid, tx_bit, tx_last} = '0;
		tx_gap_sel = GAP_ACK;
		resetn = 1'b0;
		void'($urandom(32'h14c7));
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		// Receive random frames, then time the idle gap that follows.
		for (int f = 0; f < 3; f++) begin
			// The last bit is a one, so the frame ends on an asserted line.
			// Otherwise the idle time could start a whole cell before release.
			b = {1'b1, 7'($urandom)};
			for (int i = 0; i < 8; i++)
				q_rx.push_back(b[i]);
			bus.send(b);
			{ta, ts, n} = '0;
			while (gap_status.arb_reset_gap !== 1'b1 && n < 150) begin
				@(negedge clk);
				n++;
				if (ack_gap === 1'b1 && ta == 0)
					ta = n;
				if (gap_status.sub_gap === 1'b1 && ts == 0)
					ts = n;
			end
			chk_rng(q_rx.size(), 0, 0);
			chk_rng(ta, exp_cyc(4) - 2, exp_cyc(4) + 3);
			chk_rng(ts, exp_cyc(16) - 2, exp_cyc(16) + 3);
			chk_rng(n, exp_cyc(28) - 2, exp_cyc(28) + 3);
			repeat (30) @(negedge clk);
			chk_bit(gap_status.sub_gap, 1'b1);
			chk_bit(gap_status.arb_reset_gap, 1'b1);
			chk_bit(gap_status.spare[f % 2], 1'b0);
			// One active line alone must end the idle period.
			if (f[0])
				bus.drv_s = 1'b1;
			else
				bus.drv_d = 1'b1;
			@(negedge clk);
			{bus.drv_s, bus.drv_d} = 2'b00;
			repeat (5) @(negedge clk);
			chk_bit(ack_gap, 1'b0);
			chk_bit(gap_status.arb_reset_gap, 1'b0);
		end
		$display("Test receive and gaps done");
		// Transmit after each gap: wired-OR slow, totem slow, and wired-OR
		// fast with transfer mode also set, where arbitration must win.
		for (int s = 0; s < 3; s++) begin
			arb_mode = (s != 1);
			xfer_mode = (s != 0);
			fast_rate = (s == 2);
			tx_gap_sel = bgd_gap_sel_t'(s);
			bus.drv_d = 1'b1;
			// The request waits until the activity has cleared the idle
			// count, so a stale count cannot start the send at once.
			repeat (3) @(negedge clk);
			tx_req = 1'b1;
			repeat (2) @(negedge clk);
			bus.drv_d = 1'b0;
			n = 0;
			while (tx_ready !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			// Not before the hold-off, and promptly after it.
			ta = exp_cyc(hold[s]);
			chk_rng(n, ta - 2, 999);
			chk_rng(n, 0, ta + 6);
			b = 8'($urandom);
			{pb, ps, tot} = '0;
			tx_valid = 1'b1;
			for (int i = 0; i < 8; i++) begin
				tx_bit = b[i];
				tx_last = (i == 7);
				n = 0;
				while (tx_ready !== 1'b1 && n < 20) begin
					@(negedge clk);
					n++;
				end
				@(negedge clk);
				ps = (b[i] == pb) ? ~ps : ps;
				pb = b[i];
				if (i > 0)
					tot += n + 1;
				chk_bit(tx_data_line.o, pb);
				chk_bit(tx_strobe_line.o, ps);
				chk_bit(tx_data_line.oe, arb_mode ? pb : 1'b1);
				chk_bit(tx_strobe_line.oe, arb_mode ? ps : 1'b1);
			end
			{tx_valid, tx_last} = 2'b00;
			chk_rng(tot, fast_rate ? 6 : 15, fast_rate ? 12 : 21);
			n = 0;
			while (tx_busy !== 1'b0 && n < 20) begin
				@(negedge clk);
				n++;
			end
			chk_rng(n, 0, 19);
			chk_bit(tx_data_line.o, 1'b0);
			chk_bit(tx_data_line.oe, 1'b0);
			tx_req = 1'b0;
			$display("Test transmit %0d done", s);
		end
		complete_run();
	end
endmodule
`default_nettype wire
